// ===== rtl/vec_irq_top.sv
// Contract
// - Core timer vector 0, software vectors 1,2
// - Flag and enable at bit n
// - Four vectors share one priority register
// - Capture error and event separate vectors
// - Priority field encodes levels 1 to 7
// - Priority zero means source disabled
// - Subpriority field encodes levels 0 to 3
// - Three bits above priority read zero
// - Priority bits 4-2, subpriority 1-0
// - Absent variant sources never raised
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "vec_irq_cfg.svh"

module vec_irq_top
    import vec_irq_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [28:0] src_event_in,
    input wire logic core_ack_in,
    output logic irq_valid_out,
    output vector_t irq_vector_out,
    output prio_t irq_prio_out,
    output sub_t irq_sub_out
);

    // ---------------------------------------------
    // Registers
    // ---------------------------------------------
    logic [31:0] request_flag_register_0_r;
    logic [31:0] source_enable_register_0_r;
    logic [31:0] variant_mask_r;
    logic [231:0] prio_flat;
    logic [31:0] priority_control_register_r [0:`LAST_PRIO_REG];
    bus_state_t bus_state_r;
    logic [31:0] rdata_nxt;
    logic [31:0] wmask;
    logic acc;
    logic [28:0] pending;
    logic win_valid;
    vector_t win_vec;
    prio_t win_prio;
    sub_t win_sub;
    logic [4:0] prio_idx;
    logic [31:0] request_flag_nxt;
    logic [28:0] new_events;
    logic sel_flag;
    logic sel_enable;
    logic sel_prio;
    logic sel_status;
    logic sel_variant;
    logic wr_commit;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable_in[b]}};
        end
    end

    assign acc = (avs_read_in || avs_write_in) && bus_state_r == BUS_IDLE;
    assign prio_idx = 5'((avs_address_in - `OFS_PRIO_BASE) >> 2);

    // ---------------------------------------------
    // Address decode
    // ---------------------------------------------
    always_comb begin
        sel_flag = 1'b0;
        sel_enable = 1'b0;
        sel_prio = 1'b0;
        sel_status = 1'b0;
        sel_variant = 1'b0;
        if (avs_address_in == `OFS_FLAG) begin
            sel_flag = 1'b1;
        end else if (avs_address_in == `OFS_ENABLE) begin
            sel_enable = 1'b1;
        end else if (avs_address_in >= `OFS_PRIO_BASE && avs_address_in <= `OFS_PRIO_LAST &&
            avs_address_in[1:0] == 2'h0) begin
            // Misaligned priority addresses fall through: read zero, write nothing
            sel_prio = 1'b1;
        end else if (avs_address_in == `OFS_STATUS) begin
            sel_status = 1'b1;
        end else if (avs_address_in == `OFS_VARIANT) begin
            sel_variant = 1'b1;
        end
    end

    // A write lands only at the edge where waitrequest is low
    assign wr_commit = bus_state_r == BUS_ACK && avs_write_in;

    // ---------------------------------------------
    // Bus handshake: one wait cycle then answer
    // ---------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            case (bus_state_r)
                BUS_IDLE: if (avs_read_in || avs_write_in) bus_state_r <= BUS_ACK;
                default: bus_state_r <= BUS_IDLE;
            endcase
        end
    end

    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && bus_state_r != BUS_ACK;

    // ---------------------------------------------
    // Flags: hardware set beats software clear
    // ---------------------------------------------
    assign new_events = src_event_in & variant_mask_r[28:0];

    always_comb begin
        request_flag_nxt = request_flag_register_0_r;
        if (wr_commit && sel_flag) begin
            request_flag_nxt = (request_flag_nxt & ~wmask) | (avs_writedata_in & wmask);
        end
        if (irq_valid_out && core_ack_in) begin
            request_flag_nxt[irq_vector_out] = 1'b0;
        end
        // Set applied last so an event never loses to a clear in the same cycle
        request_flag_nxt[28:0] = request_flag_nxt[28:0] | new_events;
        request_flag_nxt[31:29] = 3'h0;
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            request_flag_register_0_r <= `FLAG_RST;
        end else begin
            request_flag_register_0_r <= request_flag_nxt;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            source_enable_register_0_r <= `ENABLE_RST;
            variant_mask_r <= `VARIANT_RST;
        end else if (bus_state_r == BUS_ACK && avs_write_in) begin
            if (avs_address_in == `OFS_ENABLE) begin
                source_enable_register_0_r <= ((source_enable_register_0_r & ~wmask) |
                    (avs_writedata_in & wmask)) & 32'h1FFF_FFFF;
            end else if (avs_address_in == `OFS_VARIANT) begin
                // Vector 28 is reserved and stays absent
                variant_mask_r <= ((variant_mask_r & ~wmask) |
                    (avs_writedata_in & wmask)) & 32'h0FFF_FFFF;
            end
        end
    end

    // ---------------------------------------------
    // Priority registers, four lanes each
    // ---------------------------------------------
    genvar g;
    generate
        for (g = 0; g <= `LAST_PRIO_REG; g++) begin : gen_prio
            always_ff @(posedge core_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    priority_control_register_r[g] <= `PRIO_RST;
                end else if (wr_commit && sel_prio && prio_idx == 5'(g)) begin
                    // Top three bits of each lane are unimplemented
                    priority_control_register_r[g] <= ((priority_control_register_r[g] & ~wmask) |
                        (avs_writedata_in & wmask)) & 32'h1F1F_1F1F;
                end
            end
        end
        for (g = 0; g < `NUM_VEC; g++) begin : gen_lane
            if (g < 28) begin : gen_real
                // Lane g%4 of register g/4: bits 4-2 level, 1-0 sub
                assign prio_flat[g*8 +: 8] =
                    priority_control_register_r[g/4][(g%4)*`LANE_BITS +: 8];
            end else begin : gen_rsv
                assign prio_flat[g*8 +: 8] = 8'h00;
            end
        end
    endgenerate

    // ---------------------------------------------
    // Read mux
    // ---------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (sel_flag) begin
            rdata_nxt = request_flag_register_0_r;
        end else if (sel_enable) begin
            rdata_nxt = source_enable_register_0_r;
        end else if (sel_prio) begin
            rdata_nxt = priority_control_register_r[prio_idx[2:0]];
        end else if (sel_status) begin
            rdata_nxt = {16'h0000, win_valid, 2'h0, win_vec, 3'h0, win_prio, win_sub};
        end else if (sel_variant) begin
            rdata_nxt = variant_mask_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (acc && avs_read_in) begin
            avs_readdata_out <= rdata_nxt;
        end
    end

    // ---------------------------------------------
    // Arbitration toward the core
    // ---------------------------------------------
    // Vector index equals flag bit, so the capture error and event of
    // a channel (e.g. 20, 21) and vectors 0..2 stay fixed.
    assign pending = request_flag_register_0_r[28:0] & source_enable_register_0_r[28:0] &
        variant_mask_r[28:0];

    vec_irq_arbiter u_arb (
        .req_in(pending),
        .prio_in(prio_flat),
        .valid_out(win_valid),
        .vec_out(win_vec),
        .prio_out(win_prio),
        .sub_out(win_sub)
    );

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_valid_out <= 1'b0;
            irq_vector_out <= `VEC_CORE_TIMER;
            irq_prio_out <= 3'h0;
            irq_sub_out <= 2'h0;
        end else begin
            irq_valid_out <= win_valid && !(irq_valid_out && core_ack_in);
            irq_vector_out <= win_vec;
            irq_prio_out <= win_prio;
            irq_sub_out <= win_sub;
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    a_zero_prio_silent: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out |-> irq_prio_out != 3'h0) else $error("zero priority presented");
    a_lane_top_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (priority_control_register_r[1] & 32'hE0E0_E0E0) == 32'h0)
        else $error("unimplemented lane bits set");
    a_absent_never: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out |-> variant_mask_r[irq_vector_out] && irq_vector_out != `VEC_RESERVED)
        else $error("absent vector raised");
    a_win_enabled: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        win_valid |-> pending[win_vec] && prio_flat[win_vec*8+2 +: 3] == win_prio)
        else $error("winner not pending or wrong priority");
    a_out_follows: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        win_valid && !(irq_valid_out && core_ack_in) |=> irq_valid_out &&
        irq_vector_out == $past(win_vec)) else $error("output lost winner");
    a_flag_sets: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        src_event_in[4] && variant_mask_r[4] |=> request_flag_register_0_r[4])
        else $error("event flag not set");
    a_sub_field: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        win_valid |-> win_sub == prio_flat[win_vec*8 +: 2])
        else $error("subpriority wrong");
    a_vec5_lane: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        prio_flat[42 +: 3] == priority_control_register_r[1][12:10])
        else $error("vector 5 lane mismatch");
    a_lane1_fields: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        prio_flat[10 +: 3] == priority_control_register_r[0][12:10] &&
        prio_flat[8 +: 2] == priority_control_register_r[0][9:8])
        else $error("lane 1 field layout wrong");
    a_cap_pair: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        prio_flat[160 +: 8] == priority_control_register_r[5][7:0] &&
        prio_flat[168 +: 8] == priority_control_register_r[5][15:8])
        else $error("capture error and event lanes merged");
    a_win_nonzero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        win_valid |-> win_prio != 3'h0) else $error("zero priority won");
    a_timer_vec0: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out && irq_vector_out == `VEC_CORE_TIMER |-> $past(pending[0]))
        else $error("vector 0 without timer request");
    a_soft0_vec1: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out && irq_vector_out == `VEC_SOFT0 |-> $past(pending[1]))
        else $error("vector 1 without software request 0");
    a_soft1_vec2: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out && irq_vector_out == `VEC_SOFT1 |-> $past(pending[2]))
        else $error("vector 2 without software request 1");

    // ---------------------------------------------
    // Flag and bus checks
    // ---------------------------------------------
    a_set_wins: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        new_events != 29'h0 |=>
        (request_flag_register_0_r[28:0] & $past(new_events)) == $past(new_events))
        else $error("event lost to a clear");
    a_ack_clears: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out && core_ack_in && !new_events[irq_vector_out] |=>
        !request_flag_register_0_r[$past(irq_vector_out)]) else $error("taken flag not cleared");
    a_flag_top_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        request_flag_register_0_r[31:29] == 3'h0 && source_enable_register_0_r[31:29] == 3'h0)
        else $error("flag or enable bit above vector 28 set");
    a_ack_drops: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        irq_valid_out && core_ack_in |=> !irq_valid_out) else $error("request held after ack");
    a_rd_lane_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        acc && avs_read_in && sel_prio |=> (avs_readdata_out & 32'hE0E0_E0E0) == 32'h0)
        else $error("unimplemented lane bits read back");
    a_status_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        acc && avs_read_in && sel_status |=> avs_readdata_out[12:8] == $past(win_vec))
        else $error("status vector wrong");
    a_status_valid: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        acc && avs_read_in && sel_status |=> avs_readdata_out[15] == $past(win_valid))
        else $error("status valid bit wrong");
endmodule : vec_irq_top

// ===== rtl/vec_irq_cfg.svh
`ifndef VEC_IRQ_CFG_SVH
`define VEC_IRQ_CFG_SVH

// Register byte offsets
`define OFS_FLAG 8'h00
`define OFS_ENABLE 8'h04
`define OFS_PRIO_BASE 8'h10
`define OFS_PRIO_LAST 8'h28
`define OFS_STATUS 8'h40
`define OFS_VARIANT 8'h44

// Field layout inside one priority lane
`define PRIO_LSB 2
`define SUB_LSB 0
`define LANE_BITS 8

// Reset values
`define FLAG_RST 32'h0000_0000
`define ENABLE_RST 32'h0000_0000
`define PRIO_RST 32'h0000_0000
`define VARIANT_RST 32'h0FFF_FFFF

// Vector counts and fixed vectors
`define NUM_VEC 29
`define VEC_CORE_TIMER 5'h00
`define VEC_SOFT0 5'h01
`define VEC_SOFT1 5'h02
`define VEC_RESERVED 5'h1C
`define LAST_PRIO_REG 6

`endif

// ===== rtl/vec_irq_pkg.sv
package vec_irq_pkg;
    typedef logic [4:0] vector_t;
    typedef logic [2:0] prio_t;
    typedef logic [1:0] sub_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage : vec_irq_pkg

// ===== rtl/vec_irq_arbiter.sv
`timescale 1ns/100ps
`include "vec_irq_cfg.svh"

module vec_irq_arbiter
    import vec_irq_pkg::*;
(
    input wire logic [28:0] req_in,
    input wire logic [231:0] prio_in,
    output logic valid_out,
    output vector_t vec_out,
    output prio_t prio_out,
    output sub_t sub_out
);
    always_comb begin
        valid_out = 1'b0;
        vec_out = 5'h00;
        prio_out = 3'h0;
        sub_out = 2'h0;
        // Ascending scan with strict compare keeps lower vector on ties
        for (int i = 0; i < `NUM_VEC; i++) begin
            if (req_in[i] && prio_in[i*8+2 +: 3] != 3'h0 &&
                (!valid_out || prio_in[i*8+2 +: 3] > prio_out ||
                (prio_in[i*8+2 +: 3] == prio_out && prio_in[i*8 +: 2] > sub_out))) begin
                valid_out = 1'b1;
                vec_out = vector_t'(i);
                prio_out = prio_in[i*8+2 +: 3];
                sub_out = prio_in[i*8 +: 2];
            end
        end
    end
endmodule : vec_irq_arbiter

// ===== verification/irq_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Core taking vectors, prompt or slow
// ----------------------------------------
module irq_core_model
    import vec_irq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic irq_valid_in,
    input wire vector_t irq_vector_in,
    input wire logic ack_en_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output vector_t taken_vec_out,
    output logic [7:0] taken_cnt_out
);
    logic [3:0] wait_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_r <= 4'h0;
            ack_out <= 1'b0;
        end else if (ack_out) begin
            ack_out <= 1'b0;
            wait_r <= 4'h0;
        end else if (irq_valid_in && ack_en_in && wait_r == delay_in) begin
            ack_out <= 1'b1;
        end else if (irq_valid_in && ack_en_in) begin
            wait_r <= wait_r + 4'h1;
        end else begin
            wait_r <= 4'h0;
        end
    end
    // The vector counts as taken at the edge that samples the acknowledge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            taken_vec_out <= 5'h00;
            taken_cnt_out <= 8'h00;
        end else if (ack_out && irq_valid_in) begin
            taken_vec_out <= irq_vector_in;
            taken_cnt_out <= taken_cnt_out + 8'h01;
        end
    end
endmodule : irq_core_model

// ===== verification/vectored_interrupt_priority_map_tb_top.sv
`timescale 1ns/100ps
`include "vec_irq_cfg.svh"
`define CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module vectored_interrupt_priority_map_tb_top
    import vec_irq_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic [28:0] events = 29'h0;
    logic ack_en = 1'b0;
    logic [3:0] delay = 4'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic ack;
    logic ivalid;
    vector_t ivec;
    vector_t tvec;
    prio_t iprio;
    prio_t p;
    sub_t isub;
    sub_t s;
    logic [7:0] tcnt;
    logic [7:0] base;
    logic [31:0] st;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    vec_irq_top i_dut (.core_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .src_event_in(events), .core_ack_in(ack), .irq_valid_out(ivalid),
        .irq_vector_out(ivec), .irq_prio_out(iprio), .irq_sub_out(isub));
    irq_core_model i_core (.clk_in(clk), .nrst_in(nrst), .irq_valid_in(ivalid),
        .irq_vector_in(ivec), .ack_en_in(ack_en), .delay_in(delay), .ack_out(ack),
        .taken_vec_out(tvec), .taken_cnt_out(tcnt));
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] m, output logic [31:0] r);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        be <= m;
        do @(posedge clk); while (waitreq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
        logic [31:0] r;
        bus(1'b1, a, d, m, r);
    endtask : wr_reg
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 4'h0, r);
        `CHK(nm, e, r)
    endtask : rd_chk
    task automatic fire(input logic [28:0] m);
        @(posedge clk);
        events <= m;
        @(posedge clk);
        events <= 29'h0;
        repeat (3) @(posedge clk);
    endtask : fire
    task automatic take(input logic [7:0] c, input vector_t v);
        int k;
        k = 0;
        while (tcnt !== c && k < 100) begin
            @(negedge clk);
            k++;
        end
        `CHK("taken vector", {c, v}, {tcnt, tvec})
    endtask : take
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd_chk("flag", `OFS_FLAG, `FLAG_RST);
        rd_chk("enable", `OFS_ENABLE, `ENABLE_RST);
        for (int k = 0; k <= `LAST_PRIO_REG; k++) begin
            rd_chk("prio reg", `OFS_PRIO_BASE + 8'(4 * k), `PRIO_RST);
        end
        rd_chk("variant", `OFS_VARIANT, `VARIANT_RST);
        wr_reg(`OFS_PRIO_BASE + 8'h04, 32'hFFFF_FFFF, 4'hF);
        rd_chk("prio lanes", `OFS_PRIO_BASE + 8'h04, 32'h1F1F_1F1F);
        wr_reg(8'h80, 32'hFFFF_FFFF, 4'hF);
        rd_chk("unmapped", 8'h80, 32'h0);
        wr_reg(`OFS_ENABLE, 32'hFFFF_FFFF, 4'hF);
        rd_chk("enable all", `OFS_ENABLE, 32'h1FFF_FFFF);
        for (int n = 0; n < 28; n++) begin
            p = prio_t'(n % 7 + 1);
            s = sub_t'(n % 4);
            base = `OFS_PRIO_BASE + 8'(4 * (n / 4));
            wr_reg(base, {4{3'h0, p, s}}, 4'h1 << (n % 4));
            fire(29'h1 << n);
            rd_chk("flag bit", `OFS_FLAG, 32'h1 << n);
            st = {16'h0000, 1'b1, 2'h0, vector_t'(n), 3'h0, p, s};
            rd_chk("status", `OFS_STATUS, st);
            @(negedge clk);
            `CHK("vector", {1'b1, vector_t'(n)}, {ivalid, ivec})
            `CHK("prio sub", {p, s}, {iprio, isub})
            @(posedge clk);
            ack_en <= 1'b1;
            take(8'(n + 1), vector_t'(n));
            @(posedge clk);
            ack_en <= 1'b0;
        end
        fire(29'h1 << 28);
        `CHK("reserved", 1'b0, ivalid)
        wr_reg(`OFS_PRIO_BASE, 32'h0, 4'h8);
        fire(29'h1 << 3);
        `CHK("prio zero", 1'b0, ivalid)
        rd_chk("held flag", `OFS_FLAG, 32'h8);
        wr_reg(`OFS_PRIO_BASE, 32'h0800_0000, 4'h8);
        ack_en <= 1'b1;
        take(8'h1D, 5'h03);
        wr_reg(`OFS_VARIANT, 32'h0FFF_FDFF, 4'hF);
        fire(29'h1 << 9);
        `CHK("absent", 1'b0, ivalid)
        wr_reg(`OFS_PRIO_BASE + 8'h08, 32'h1211_0000, 4'hC);
        wr_reg(`OFS_PRIO_BASE + 8'h0C, 32'h0000_0012, 4'h1);
        delay <= 4'h3;
        fire(29'h1C00);
        take(8'h1E, 5'h0B);
        take(8'h1F, 5'h0C);
        take(8'h20, 5'h0A);
        report_and_stop();
    end
endmodule : vectored_interrupt_priority_map_tb_top
